// ==== src/etsi_pkg.sv ====
// Constants, types and record layouts for the four-channel edge time-stamp input block
// Summary of operation
// - Input image length fixed to variant, 14h/3Ch
// - Output image length reads zero, unused
// - Per-channel delay byte: 00h/02h/04h filter
// - Codes 07h/09h/0Ch; other codes are stored but filter as 02h
// - Rising enable bits 0-3, upper reserved
// - Falling enable bits 0-3, upper reserved
// - Enabled edge stores ticker plus input states
// - New entry at +0, older shift four
// - Twenty-byte variant holds five entries
// - Sixty-byte variant holds fifteen entries
// - Full image drops oldest entry
// - No interrupts; diagnostics read on demand
// - Record set 01h full, 00h four bytes
// - Object index 2F01h full, 2F00h short
// - Slot access subindices under index 5005h
// - Diag constants 1Fh,70h,00h,04h; errors zero
// - Diag ticker captured at record generation
// - Module info: class 1111b, bit4 channel flag
package etsi_pkg;
  localparam int NUM_CH = 4;
  localparam int ENTRY_BYTES = 4;
  localparam logic [7:0] IMG_LEN_SHORT = 8'h14;
  localparam logic [7:0] IMG_LEN_LONG = 8'h3c;
  localparam int ENTRIES_SHORT = 5;
  localparam int ENTRIES_LONG = 15;
  localparam logic [7:0] PIQ_LEN = 8'h00;
  localparam logic [7:0] DELAY_RESET = 8'h02;
  localparam logic [7:0] EDGE_EN_RESET = 8'h00;
  // Delay codes
  localparam logic [7:0] DLY_C1 = 8'h00;
  localparam logic [7:0] DLY_C3 = 8'h02;
  localparam logic [7:0] DLY_C10 = 8'h04;
  localparam logic [7:0] DLY_C86 = 8'h07;
  localparam logic [7:0] DLY_C342 = 8'h09;
  localparam logic [7:0] DLY_C2731 = 8'h0c;
  // Delay times in microseconds
  localparam int DLY_US1 = 1;
  localparam int DLY_US3 = 3;
  localparam int DLY_US10 = 10;
  localparam int DLY_US86 = 86;
  localparam int DLY_US342 = 342;
  localparam int DLY_US2731 = 2731;
  localparam int CLK_MHZ = 250;
  localparam int CYC1 = DLY_US1 * CLK_MHZ;
  localparam int CYC3 = DLY_US3 * CLK_MHZ;
  localparam int CYC10 = DLY_US10 * CLK_MHZ;
  localparam int CYC86 = DLY_US86 * CLK_MHZ;
  localparam int CYC342 = DLY_US342 * CLK_MHZ;
  localparam int CYC2731 = DLY_US2731 * CLK_MHZ;
  localparam int FILT_W = 20;
  // Parameter byte addresses (record set 02h / 01h / 80h contents flattened)
  localparam logic [3:0] PAR_IMG_LEN = 4'h0;
  localparam logic [3:0] PAR_PIQ_LEN = 4'h1;
  localparam logic [3:0] PAR_DLY0 = 4'h2;
  localparam logic [3:0] PAR_RISE = 4'h6;
  localparam logic [3:0] PAR_FALL = 4'h7;
  // Diagnostic record
  localparam int DIAG_BYTES = 20;
  localparam int DIAG_SHORT_BYTES = 4;
  localparam logic [7:0] RECSET_DIAG_SHORT = 8'h00;
  localparam logic [7:0] RECSET_DIAG_FULL = 8'h01;
  localparam logic [15:0] OBJ_DIAG_SHORT = 16'h2f00;
  localparam logic [15:0] OBJ_DIAG_FULL = 16'h2f01;
  localparam logic [15:0] OBJ_DIAG_SLOT = 16'h5005;
  localparam logic [7:0] SUBIDX_FIRST = 8'h02;
  localparam logic [3:0] MOD_CLASS_DIGITAL = 4'hf;
  localparam int MOD_CHINFO_BIT = 4;
  localparam logic [7:0] MOD_INFO = 8'h1f;
  localparam logic [7:0] CH_TYPE = 8'h70;
  localparam logic [7:0] DIAG_BITS = 8'h00;
  localparam logic [7:0] CH_COUNT = 8'h04;
  localparam logic [7:0] DIAG_RSVD = 8'h00;
  localparam int DIAG_POS_MODINFO = 1;
  localparam int DIAG_POS_CHTYPE = 4;
  localparam int DIAG_POS_BITS = 5;
  localparam int DIAG_POS_CHCOUNT = 6;
  localparam int DIAG_POS_TICKER = 16;

  typedef enum logic [1:0] {
    ETSI_SEL_DIAG_FULL = 2'b00,
    ETSI_SEL_DIAG_SHORT = 2'b01,
    ETSI_SEL_NONE = 2'b10
  } etsi_sel_e;

  // Entry: ticker low 28 bits above the four input states
  typedef struct packed {
    logic [27:0] ticker;
    logic [3:0] inputs;
  } etsi_entry_s;

  typedef struct packed {
    logic valid;
    logic [7:0] record_set;
    logic [15:0] object_index;
    logic [7:0] object_subindex;
    logic [4:0] byte_idx;
  } etsi_diag_req_s;
endpackage : etsi_pkg

// ==== src/etsi_filter.sv ====
// Input delay filter for one channel
`timescale 1ns/1ns
`default_nettype none
module etsi_filter (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_raw,
  input wire logic [7:0] i_delay_code,
  output logic o_level
);
  logic [etsi_pkg::FILT_W-1:0] cnt_q;
  logic [etsi_pkg::FILT_W-1:0] limit;

  always_comb begin
    unique case (i_delay_code)
      etsi_pkg::DLY_C1: limit = etsi_pkg::FILT_W'(etsi_pkg::CYC1);
      etsi_pkg::DLY_C3: limit = etsi_pkg::FILT_W'(etsi_pkg::CYC3);
      etsi_pkg::DLY_C10: limit = etsi_pkg::FILT_W'(etsi_pkg::CYC10);
      etsi_pkg::DLY_C86: limit = etsi_pkg::FILT_W'(etsi_pkg::CYC86);
      etsi_pkg::DLY_C342: limit = etsi_pkg::FILT_W'(etsi_pkg::CYC342);
      etsi_pkg::DLY_C2731: limit = etsi_pkg::FILT_W'(etsi_pkg::CYC2731);
      // Forbidden code: fall back to the reset setting
      default: limit = etsi_pkg::FILT_W'(etsi_pkg::CYC3);
    endcase
  end

  // Level must differ for the full delay before it is taken; spikes reset the count
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      o_level <= 1'b0;
    end else if (i_raw == o_level) begin
      cnt_q <= '0;
    end else if (cnt_q + 1'b1 >= limit) begin
      cnt_q <= '0;
      o_level <= i_raw;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : etsi_filter
`default_nettype wire

// ==== src/etsi_top.sv ====
// Edge time-stamp input block: filters, edge capture, shifting image, parameters, diagnostics
`timescale 1ns/1ns
`default_nettype none
module etsi_top #(
  parameter bit LONG_VARIANT = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [3:0] i_input_channel,
  input wire logic [31:0] i_us_ticker,
  input wire logic i_par_wr,
  input wire logic [3:0] i_par_addr,
  input wire logic [7:0] i_par_wdata,
  input wire logic [3:0] i_par_raddr,
  input wire logic [5:0] i_img_raddr,
  input wire etsi_pkg::etsi_diag_req_s i_diag_req,
  output logic [7:0] o_par_rdata,
  output logic [7:0] o_img_rdata,
  output logic [7:0] o_diag_rdata,
  output logic o_diag_valid,
  output logic o_diag_err,
  output logic [3:0] o_input_state,
  output logic [3:0] o_entry_count
);
  // ****************************************
  // Image geometry
  // ****************************************
  localparam int MAX_ENT = LONG_VARIANT ? etsi_pkg::ENTRIES_LONG : etsi_pkg::ENTRIES_SHORT;
  localparam logic [7:0] IMG_LEN = LONG_VARIANT ? etsi_pkg::IMG_LEN_LONG : etsi_pkg::IMG_LEN_SHORT;

  logic [7:0] delay_q [etsi_pkg::NUM_CH];
  logic [3:0] rise_en_q;
  logic [3:0] fall_en_q;
  logic [3:0] filt;
  logic [3:0] filt_prev_q;
  etsi_pkg::etsi_entry_s image_q [etsi_pkg::ENTRIES_LONG];
  logic [3:0] count_q;
  logic [31:0] diag_ticker_q;
  logic stamp;

  // ****************************************
  // Parameters
  // ****************************************
  // Writes are accepted whenever offered; the head only sends them in STOP
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < etsi_pkg::NUM_CH; i++) begin
        delay_q[i] <= etsi_pkg::DELAY_RESET;
      end
    end else if (i_par_wr && i_par_addr >= etsi_pkg::PAR_DLY0
                 && i_par_addr < etsi_pkg::PAR_RISE) begin
      delay_q[2'(i_par_addr - etsi_pkg::PAR_DLY0)] <= i_par_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_en_q <= etsi_pkg::EDGE_EN_RESET[3:0];
      fall_en_q <= etsi_pkg::EDGE_EN_RESET[3:0];
    end else if (i_par_wr) begin
      if (i_par_addr == etsi_pkg::PAR_RISE) begin
        rise_en_q <= i_par_wdata[3:0];
      end
      if (i_par_addr == etsi_pkg::PAR_FALL) begin
        fall_en_q <= i_par_wdata[3:0];
      end
    end
  end

  // Length bytes are constants and ignore writes
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_par_rdata <= 8'h00;
    end else begin
      if (i_par_raddr == etsi_pkg::PAR_IMG_LEN) begin
        o_par_rdata <= IMG_LEN;
      end else if (i_par_raddr == etsi_pkg::PAR_PIQ_LEN) begin
        o_par_rdata <= etsi_pkg::PIQ_LEN;
      end else if (i_par_raddr >= etsi_pkg::PAR_DLY0 && i_par_raddr < etsi_pkg::PAR_RISE) begin
        o_par_rdata <= delay_q[2'(i_par_raddr - etsi_pkg::PAR_DLY0)];
      end else if (i_par_raddr == etsi_pkg::PAR_RISE) begin
        o_par_rdata <= {4'h0, rise_en_q};
      end else if (i_par_raddr == etsi_pkg::PAR_FALL) begin
        o_par_rdata <= {4'h0, fall_en_q};
      end else begin
        o_par_rdata <= 8'h00;
      end
    end
  end

  // ****************************************
  // Filters and edge detect
  // ****************************************
  for (genvar c = 0; c < etsi_pkg::NUM_CH; c++) begin : g_ch
    etsi_filter u_filt (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_raw(i_input_channel[c]),
      .i_delay_code(delay_q[c]),
      .o_level(filt[c])
    );
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      filt_prev_q <= 4'h0;
      o_input_state <= 4'h0;
    end else begin
      filt_prev_q <= filt;
      o_input_state <= filt;
    end
  end

  // Simultaneous edges on several channels make one shared entry
  assign stamp = |((filt & ~filt_prev_q & rise_en_q) | (~filt & filt_prev_q & fall_en_q));

  // ****************************************
  // Shifting image
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < etsi_pkg::ENTRIES_LONG; i++) begin
        image_q[i] <= '0;
      end
      count_q <= 4'h0;
    end else if (stamp) begin
      image_q[0] <= '{ticker: i_us_ticker[27:0], inputs: filt};
      for (int i = 1; i < MAX_ENT; i++) begin
        image_q[i] <= image_q[i-1];
      end
      if (count_q < 4'(MAX_ENT)) begin
        count_q <= count_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_entry_count <= 4'h0;
    end else begin
      o_entry_count <= count_q;
    end
  end

  // Little-endian bytes of each 32-bit entry
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_img_rdata <= 8'h00;
    end else if (i_img_raddr < 6'(IMG_LEN)) begin
      o_img_rdata <= image_q[4'(i_img_raddr[5:2])][8*i_img_raddr[1:0] +: 8];
    end else begin
      o_img_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Diagnostics
  // ****************************************
  function automatic etsi_pkg::etsi_sel_e diag_sel(input etsi_pkg::etsi_diag_req_s r);
    if (r.record_set == etsi_pkg::RECSET_DIAG_FULL && r.object_index == 16'h0000) begin
      return etsi_pkg::ETSI_SEL_DIAG_FULL;
    end else if (r.record_set == etsi_pkg::RECSET_DIAG_SHORT && r.object_index == 16'h0000) begin
      return etsi_pkg::ETSI_SEL_DIAG_SHORT;
    end else if (r.object_index == etsi_pkg::OBJ_DIAG_FULL || r.object_index == etsi_pkg::OBJ_DIAG_SLOT) begin
      return etsi_pkg::ETSI_SEL_DIAG_FULL;
    end else if (r.object_index == etsi_pkg::OBJ_DIAG_SHORT) begin
      return etsi_pkg::ETSI_SEL_DIAG_SHORT;
    end
    return etsi_pkg::ETSI_SEL_NONE;
  endfunction : diag_sel

  function automatic logic [7:0] diag_byte(input int unsigned idx, input logic [31:0] tick);
    if (idx == etsi_pkg::DIAG_POS_MODINFO) begin
      return etsi_pkg::MOD_INFO;
    end else if (idx == etsi_pkg::DIAG_POS_CHTYPE) begin
      return etsi_pkg::CH_TYPE;
    end else if (idx == etsi_pkg::DIAG_POS_BITS) begin
      return etsi_pkg::DIAG_BITS;
    end else if (idx == etsi_pkg::DIAG_POS_CHCOUNT) begin
      return etsi_pkg::CH_COUNT;
    end else if (idx >= etsi_pkg::DIAG_POS_TICKER && idx < etsi_pkg::DIAG_BYTES) begin
      return tick[8*(idx - etsi_pkg::DIAG_POS_TICKER) +: 8];
    end
    return etsi_pkg::DIAG_RSVD;
  endfunction : diag_byte

  etsi_pkg::etsi_sel_e sel;
  logic [4:0] idx;
  always_comb begin
    sel = diag_sel(i_diag_req);
    idx = (i_diag_req.object_index == etsi_pkg::OBJ_DIAG_SLOT)
          ? 5'(i_diag_req.object_subindex - etsi_pkg::SUBIDX_FIRST) : i_diag_req.byte_idx;
  end

  // Ticker snapshot taken when a read starts at byte zero, so all four bytes agree
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      diag_ticker_q <= 32'h0;
    end else if (i_diag_req.valid && idx == 5'h00) begin
      diag_ticker_q <= i_us_ticker;
    end
  end

  // Answers only on request; nothing is pushed to the head
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_diag_rdata <= 8'h00;
      o_diag_valid <= 1'b0;
      o_diag_err <= 1'b0;
    end else begin
      o_diag_valid <= 1'b0;
      o_diag_err <= 1'b0;
      o_diag_rdata <= 8'h00;
      if (i_diag_req.valid) begin
        if (sel == etsi_pkg::ETSI_SEL_NONE
            || (sel == etsi_pkg::ETSI_SEL_DIAG_SHORT && idx >= 5'(etsi_pkg::DIAG_SHORT_BYTES))
            || idx >= 5'(etsi_pkg::DIAG_BYTES)) begin
          o_diag_err <= 1'b1;
        end else begin
          o_diag_valid <= 1'b1;
          o_diag_rdata <= diag_byte(32'(idx),
                                    idx == 5'h00 ? i_us_ticker : diag_ticker_q);
        end
      end
    end
  end
endmodule : etsi_top
`default_nettype wire

// ==== bench/etsi_head_model.sv ====
// Head module model supplying the free-running microsecond ticker
`timescale 1ns/1ns
`default_nettype none
module etsi_head_model #(
  parameter int CYC_PER_US = 250,
  parameter logic [31:0] TICK_START = 32'h0ffffff0
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  output logic [31:0] o_us_ticker
);
  // ****************
  // Ticker
  // ****************
  int cnt;
  // Starts just below bit 28 so that entries must drop the upper ticker bits
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 0;
      o_us_ticker <= TICK_START;
    end else if (cnt == CYC_PER_US - 1) begin
      cnt <= 0;
      o_us_ticker <= o_us_ticker + 32'h1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : etsi_head_model
`default_nettype wire

// ==== bench/etsi_props.sv ====
// Concurrent checks on the ports of the edge time-stamp block
`timescale 1ns/1ns
`default_nettype none
module etsi_props #(
  parameter bit LONG_VARIANT = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [3:0] i_input_channel,
  input wire logic [31:0] i_us_ticker,
  input wire logic i_par_wr,
  input wire logic [3:0] i_par_addr,
  input wire logic [7:0] i_par_wdata,
  input wire logic [3:0] i_par_raddr,
  input wire logic [5:0] i_img_raddr,
  input wire etsi_pkg::etsi_diag_req_s i_diag_req,
  input wire logic [7:0] o_par_rdata,
  input wire logic [7:0] o_img_rdata,
  input wire logic [7:0] o_diag_rdata,
  input wire logic o_diag_valid,
  input wire logic o_diag_err,
  input wire logic [3:0] o_input_state,
  input wire logic [3:0] o_entry_count
);
  // ****************
  // Properties
  // ****************
  localparam logic [3:0] MAX_E = LONG_VARIANT ? 4'hf : 4'h5;
  localparam logic [5:0] LEN = LONG_VARIANT ? 6'h3c : 6'h14;
  logic [1:0] up_q;
  // Read ports answer zero on the first edge after reset
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      up_q <= 2'h0;
    end else if (!up_q[1]) begin
      up_q <= up_q + 2'h1;
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_req(o, b);
    i_diag_req.valid && i_diag_req.object_index == o && i_diag_req.byte_idx == b;
  endsequence
  AST_PII_LEN: assert property (up_q[1] && i_par_raddr == 4'h0 |=> o_par_rdata == {2'h0, LEN})
    else $error("Input length byte wrong");
  AST_PIQ_ZERO: assert property (up_q[1] && i_par_raddr == 4'h1 |=> o_par_rdata == 8'h00)
    else $error("Output length byte not zero");
  AST_EN_RSVD: assert property (i_par_raddr inside {4'h6, 4'h7} |=> o_par_rdata[7:4] == 4'h0)
    else $error("Reserved enable bits set");
  AST_UNUSED_ZERO: assert property (up_q[1] && i_img_raddr >= LEN |=> o_img_rdata == 8'h00)
    else $error("Image byte past length not zero");
  AST_ENTRY_MAX: assert property (o_entry_count <= MAX_E)
    else $error("Too many entries");
  AST_ENTRY_STEP: assert property (o_entry_count != $past(o_entry_count) |->
    o_entry_count == $past(o_entry_count) + 4'h1) else $error("Entry count jumped");
  // Count output trails the state output by one cycle
  AST_ENTRY_ON_EDGE: assert property (o_entry_count != $past(o_entry_count) |->
    $past(o_input_state) != $past(o_input_state, 2)) else $error("Entry without input change");
  AST_DIAG_ON_DEMAND: assert property (o_diag_valid || o_diag_err |->
    $past(i_diag_req.valid) && !(o_diag_valid && o_diag_err)) else $error("Unrequested diag answer");
  AST_SHORT_SET: assert property (s_req(16'h0000, i_diag_req.byte_idx) ##0 i_diag_req.record_set == 8'h00
    && i_diag_req.byte_idx > 5'h03 |=> o_diag_err && !o_diag_valid) else $error("Short set not limited");
  AST_FULL_OBJ: assert property (s_req(16'h2f01, 5'h04) |=> o_diag_valid && o_diag_rdata == 8'h70)
    else $error("Channel type byte wrong");
  AST_MOD_INFO: assert property (s_req(16'h0000, 5'h01) ##0 i_diag_req.record_set == 8'h01
    |=> o_diag_rdata == 8'h1f) else $error("Module information wrong");
  AST_SLOT: assert property (i_diag_req.valid && i_diag_req.object_index == 16'h5005
    && i_diag_req.object_subindex == 8'h08 |=> o_diag_valid && o_diag_rdata == 8'h04) else $error("Slot byte wrong");
endmodule : etsi_props
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the edge time-stamp input block
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ****************
  // Stimulus and scoreboard
  // ****************
  localparam int LEN = 20;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [3:0] din = 4'h0;
  logic par_wr = 1'b0;
  logic [3:0] par_addr = 4'h0;
  logic [7:0] par_wdata = 8'h00;
  logic [3:0] par_raddr = 4'h0;
  logic [5:0] img_raddr = 6'h00;
  etsi_pkg::etsi_diag_req_s diag_req = '0;
  logic [31:0] ticker, tick_last, tick_cap;
  logic [7:0] par_rdata, img_rdata, diag_rdata, d;
  logic diag_valid, diag_err, pend = 1'b0, pend1 = 1'b0;
  logic [3:0] in_state, entry_count, st_prev = 4'h0, ren = 4'h0, fen = 4'h0;
  logic [31:0] img[0:4] = '{default: '0};
  logic [10:0] expq[$];
  logic [10:0] item;
  logic [8:0] got;
  logic [7:0] codes[6] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c};
  int n_mismatch = 0;
  int checks = 0;
  etsi_top #(.LONG_VARIANT(1'b0)) i_etsi_top (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_input_channel(din),
    .i_us_ticker(ticker), .i_par_wr(par_wr), .i_par_addr(par_addr), .i_par_wdata(par_wdata),
    .i_par_raddr(par_raddr), .i_img_raddr(img_raddr), .i_diag_req(diag_req), .o_par_rdata(par_rdata),
    .o_img_rdata(img_rdata), .o_diag_rdata(diag_rdata), .o_diag_valid(diag_valid), .o_diag_err(diag_err),
    .o_input_state(in_state), .o_entry_count(entry_count));
  etsi_head_model i_etsi_head_model (.i_mclk(i_mclk), .i_resetn(i_resetn), .o_us_ticker(ticker));
  always #2 i_mclk = ~i_mclk;
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  // Kinds: 0 parameter byte, 1 image byte, 2 input state, 3 diag answer
  always @(posedge i_mclk) begin
    if (pend1 || diag_valid || diag_err) begin
      item = expq.pop_front();
      case (item[10:9])
        2'h0: got = {1'b0, par_rdata};
        2'h1: got = {1'b0, img_rdata};
        2'h2: got = {5'h00, in_state};
        default: got = {diag_err, diag_rdata};
      endcase
      cmp(got, item[8:0]);
    end
    if (diag_req.valid && diag_req.object_index == 16'h0000 && diag_req.byte_idx == 5'h00) tick_cap = ticker;
    pend1 <= pend;
  end
  // Entry is stamped with the ticker seen on the edge before the state change shows
  always @(negedge i_mclk) begin
    if (i_resetn && |((~st_prev & in_state & ren) | (st_prev & ~in_state & fen))) begin
      for (int k = 4; k > 0; k--) img[k] = img[k - 1];
      img[0] = {tick_last[27:0], in_state};
    end
    st_prev = in_state;
    tick_last = ticker;
  end
  task automatic rd(input logic [1:0] s, input logic [5:0] a, input logic [8:0] e);
    @(posedge i_mclk);
    par_raddr <= a[3:0];
    img_raddr <= a;
    pend <= 1'b1;
    expq.push_back({s, e});
    @(posedge i_mclk);
    pend <= 1'b0;
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    par_wr <= 1'b1;
    par_addr <= a;
    par_wdata <= v;
    @(posedge i_mclk);
    par_wr <= 1'b0;
  endtask : wr
  task automatic dg(input logic [7:0] rs, input logic [15:0] ob, input logic [7:0] sx, input logic [4:0] bi,
    input logic [8:0] e);
    @(posedge i_mclk);
    diag_req <= '{1'b1, rs, ob, sx, bi};
    expq.push_back({2'h3, e});
    @(posedge i_mclk);
    diag_req.valid <= 1'b0;
  endtask : dg
  function automatic logic [7:0] dbyte(input int i);
    case (i)
      1: return 8'h1f;
      4: return 8'h70;
      6: return 8'h04;
      16, 17, 18, 19: return tick_cap[8 * (i - 16) +: 8];
      default: return 8'h00;
    endcase
  endfunction : dbyte
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h4bc39b43));
    repeat (6) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
    rd(2'h0, 6'h02, {1'b0, etsi_pkg::DELAY_RESET});
    wr(4'h0, 8'h3c);
    wr(4'h1, 8'h05);
    rd(2'h0, 6'h00, 9'h014);
    rd(2'h0, 6'h01, 9'h000);
    // Parameters are only written before any input traffic
    for (int k = 0; k < 6; k++) begin
      wr(4'h2 + 4'(k % 4), codes[k]);
      rd(2'h0, 6'h02 + 6'(k % 4), {1'b0, codes[k]});
    end
    for (int c = 0; c < 4; c++) wr(4'h2 + 4'(c), 8'h00);
    d = 8'($urandom) | 8'h01;
    wr(4'h6, d);
    ren = d[3:0];
    rd(2'h0, 6'h06, {5'h00, d[3:0]});
    d = 8'($urandom) | 8'h01;
    wr(4'h7, d);
    fen = d[3:0];
    rd(2'h0, 6'h07, {5'h00, d[3:0]});
    $display("Test parameters done");
    din <= 4'hf;
    repeat (100) @(posedge i_mclk);
    din <= 4'h0;
    repeat (300) @(posedge i_mclk);
    rd(2'h2, 6'h00, 9'h000);
    for (int e = 0; e < 16; e++) begin
      din <= 4'($urandom);
      repeat (300) @(posedge i_mclk);
      rd(2'h2, 6'h00, {5'h00, din});
    end
    for (int a = 0; a < 24; a++) rd(2'h1, 6'(a), {1'b0, a < LEN ? img[(a / 4) % 5][8 * (a % 4) +: 8] : 8'h00});
    $display("Test time stamps done");
    for (int i = 0; i < 20; i++) dg(8'h01, 16'h0000, 8'h00, 5'(i), {1'b0, dbyte(i)});
    for (int i = 0; i < 5; i++) dg(8'h00, 16'h0000, 8'h00, 5'(i), i < 4 ? {1'b0, dbyte(i)} : 9'h100);
    dg(8'h00, 16'h2f01, 8'h00, 5'h04, 9'h070);
    dg(8'h00, 16'h2f00, 8'h00, 5'h06, 9'h100);
    dg(8'h00, 16'h5005, 8'h08, 5'h00, 9'h004);
    dg(8'h00, 16'h1234, 8'h00, 5'h00, 9'h100);
    repeat (4) @(posedge i_mclk);
    $display("Test diagnostics done");
    wrap_up();
  end
endmodule : tb
bind etsi_top etsi_props #(.LONG_VARIANT(LONG_VARIANT)) i_etsi_props (.i_mclk(i_mclk), .i_resetn(i_resetn),
  .i_input_channel(i_input_channel), .i_us_ticker(i_us_ticker), .i_par_wr(i_par_wr), .i_par_addr(i_par_addr),
  .i_par_wdata(i_par_wdata), .i_par_raddr(i_par_raddr), .i_img_raddr(i_img_raddr), .i_diag_req(i_diag_req),
  .o_par_rdata(o_par_rdata), .o_img_rdata(o_img_rdata), .o_diag_rdata(o_diag_rdata),
  .o_diag_valid(o_diag_valid), .o_diag_err(o_diag_err), .o_input_state(o_input_state),
  .o_entry_count(o_entry_count));
`default_nettype wire
